// *** design/empmf_regs.svh ***
`ifndef EMPMF_REGS_SVH
`define EMPMF_REGS_SVH
// part channel setting: 0 means disabled, 1..16 select a channel
`define EMPMF_CH_OFF 5'h00
`define EMPMF_CH_MAX 5'h10
// velocity limits and reset values
`define EMPMF_VEL_MIN 7'h01
`define EMPMF_VEL_MAX 7'h7f
`define EMPMF_VEL_DEF 7'h7f
// transpose limit in semitones and note range
`define EMPMF_XPOSE_LIM 7'sh3c
`define EMPMF_NOTE_TOP 8'sh7f
// transmit enable bit positions
`define EMPMF_EN_PROG 0
`define EMPMF_EN_BANK 1
`define EMPMF_EN_MOD 2
`define EMPMF_EN_BEND 3
`define EMPMF_EN_AFT 4
`define EMPMF_EN_VOL 5
`define EMPMF_EN_SUS 6
`define EMPMF_EN_NOTE 7
// midi status nibbles and controller numbers
`define EMPMF_ST_NOFF 4'h8
`define EMPMF_ST_NON 4'h9
`define EMPMF_ST_CC 4'hb
`define EMPMF_ST_PROG 4'hc
`define EMPMF_ST_AFT 4'hd
`define EMPMF_ST_BEND 4'he
`define EMPMF_CC_BANK_HI 7'h00
`define EMPMF_CC_BANK_LO 7'h20
`define EMPMF_CC_VOL 7'h07
`define EMPMF_CC_SUS 7'h40
// fifo shape
`define EMPMF_FIFO_DEPTH 16
`define EMPMF_FIFO_AW 4
`define EMPMF_MSG_W 24
`endif

// *** design/empmf_pkg.sv ***
package empmf_pkg;
  // kinds of played event offered to the part
  typedef enum logic [2:0] {
    EMPMF_EV_NOTE_ON,
    EMPMF_EV_NOTE_OFF,
    EMPMF_EV_MOD,
    EMPMF_EV_BEND,
    EMPMF_EV_AFT,
    EMPMF_EV_SUS
  } empmf_ev_t;
  // setup send sequence states
  typedef enum logic [2:0] {
    EMPMF_SQ_IDLE,
    EMPMF_SQ_BANK_HI,
    EMPMF_SQ_BANK_LO,
    EMPMF_SQ_PROG,
    EMPMF_SQ_VOL
  } empmf_seq_t;
endpackage : empmf_pkg

// *** design/empmf_fifo.sv ***
`include "empmf_regs.svh"
module empmf_fifo #(
  parameter int WIDTH = `EMPMF_MSG_W,
  parameter int DEPTH = `EMPMF_FIFO_DEPTH,
  parameter int AW = `EMPMF_FIFO_AW
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire do_wr = wr_valid_in && wr_ready_out;
  wire do_rd = rd_valid_out && rd_ready_in;
  // full only once every entry holds a word; an empty fifo always takes
  assign wr_ready_out = (cnt_q < (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out = mem_q[rp_q];
  // pointers and count
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) wp_q <= wp_q + 1'b1;
      if (do_rd) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
  // storage written by index
  always_ff @(posedge clk_in) begin
    if (do_wr) mem_q[wp_q] <= wr_data_in;
  end
endmodule : empmf_fifo

// *** design/empmf_part.sv ***
// Summary of operation
// - channel setting off: the part sends no message at all
// - channel 1..16 enables part; that channel goes in every message
// - note-on dropped when velocity above the upper limit
// - note-on dropped when velocity below the lower limit
// - limit updates that would cross the other limit are refused
// - page-up held while a key is struck learns the upper limit
// - page-down held learns the lower limit; both may learn at once
// - use-played-velocity yes keeps key velocity, no uses default
// - per-part default velocity 1..127, used only when substituting
// - eight transmit enables gate each message type
// - setup select with bank enabled sends upper on cc0, lower on cc32
// - setup select with program enabled sends program change
// - setup select with volume enabled sends cc7 with stored level
// - all part settings stored with setup and restored on selection
// - setup order: bank upper, bank lower, program, volume
// - note numbers offset by signed transpose -60..+60
`include "empmf_regs.svh"
module empmf_part
  import empmf_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // setup restore: all settings loaded together
  input wire logic setup_load_in,
  input wire logic [4:0] part_channel_setting_in,
  input wire logic [6:0] vel_upper_in,
  input wire logic [6:0] vel_lower_in,
  input wire logic use_played_vel_in,
  input wire logic [6:0] default_vel_in,
  input wire logic [7:0] transmit_type_selector_in,
  input wire logic [6:0] bank_hi_in,
  input wire logic [6:0] bank_lo_in,
  input wire logic [6:0] program_in,
  input wire logic [6:0] volume_in,
  input wire logic signed [6:0] transpose_in,
  // limit edits from the panel
  input wire logic upper_wr_in,
  input wire logic lower_wr_in,
  input wire logic [6:0] limit_wr_data_in,
  // learn buttons
  input wire logic page_up_held_in,
  input wire logic page_down_held_in,
  // played events
  input wire logic ev_valid_in,
  output logic ev_ready_out,
  input wire logic [2:0] ev_kind_in,
  input wire logic [6:0] ev_d1_in,
  input wire logic [6:0] ev_d2_in,
  input wire logic [6:0] mod_cc_in,
  // outgoing messages: status, data1, data2
  output logic msg_valid_out,
  input wire logic msg_ready_in,
  output logic [23:0] msg_data_out,
  // settings readback
  output logic part_enabled_out,
  output logic [6:0] vel_upper_out,
  output logic [6:0] vel_lower_out,
  output logic seq_busy_out
);
  logic [4:0] chan_q;
  logic [6:0] upper_q, lower_q, defv_q, bank_hi_q, bank_lo_q, prog_q, vol_q;
  logic use_played_q;
  logic [7:0] en_q;
  logic signed [6:0] xpose_q;
  logic [127:0] sent_q;
  logic [127:0] sent_d;
  empmf_seq_t seq_q, seq_d;
  logic sq_go_q;

  // decoded settings and event fields
  wire part_on = (chan_q != `EMPMF_CH_OFF) && (chan_q <= `EMPMF_CH_MAX);
  wire [3:0] chan_nib = 4'(chan_q - 5'h01);
  wire empmf_ev_t ev_kind = empmf_ev_t'(ev_kind_in);
  wire is_on = (ev_kind == EMPMF_EV_NOTE_ON) && (ev_d2_in != 7'h00);
  wire is_off = (ev_kind == EMPMF_EV_NOTE_OFF) ||
    ((ev_kind == EMPMF_EV_NOTE_ON) && (ev_d2_in == 7'h00));
  wire signed [8:0] note_sum = $signed({2'b00, ev_d1_in}) + 9'(xpose_q);
  wire note_ok = (note_sum >= 9'sh000) && (note_sum <= 9'(`EMPMF_NOTE_TOP));
  wire [6:0] note_out = note_sum[6:0];
  wire vel_hi_ok = ev_d2_in <= upper_q;
  wire vel_lo_ok = ev_d2_in >= lower_q;
  wire [6:0] vel_out = use_played_q ? ev_d2_in : defv_q;
  // note-off only after a sent note-on
  wire off_ok = sent_q[note_out];

  // per event decision, type gating
  logic ev_send;
  logic [23:0] ev_msg;
  always_comb begin
    ev_send = 1'b0;
    ev_msg = 24'h000000;
    case (ev_kind)
      EMPMF_EV_NOTE_ON, EMPMF_EV_NOTE_OFF: begin
        if (is_on) begin
          ev_send = en_q[`EMPMF_EN_NOTE] && note_ok && vel_hi_ok && vel_lo_ok;
          ev_msg = {`EMPMF_ST_NON, chan_nib, 1'b0, note_out, 1'b0, vel_out};
        end else begin
          ev_send = note_ok && off_ok;
          ev_msg = {`EMPMF_ST_NOFF, chan_nib, 1'b0, note_out, 8'h40};
        end
      end
      EMPMF_EV_MOD: begin
        ev_send = en_q[`EMPMF_EN_MOD];
        ev_msg = {`EMPMF_ST_CC, chan_nib, 1'b0, mod_cc_in, 1'b0, ev_d2_in};
      end
      EMPMF_EV_BEND: begin
        ev_send = en_q[`EMPMF_EN_BEND];
        ev_msg = {`EMPMF_ST_BEND, chan_nib, 1'b0, ev_d1_in, 1'b0, ev_d2_in};
      end
      EMPMF_EV_AFT: begin
        ev_send = en_q[`EMPMF_EN_AFT];
        ev_msg = {`EMPMF_ST_AFT, chan_nib, 1'b0, ev_d2_in, 8'h00};
      end
      EMPMF_EV_SUS: begin
        ev_send = en_q[`EMPMF_EN_SUS];
        ev_msg = {`EMPMF_ST_CC, chan_nib, 1'b0, `EMPMF_CC_SUS, 1'b0, ev_d2_in};
      end
      default: begin
        ev_send = 1'b0;
        ev_msg = 24'h000000;
      end
    endcase
  end

  // setup sequence message
  logic [23:0] sq_msg;
  always_comb begin
    case (seq_q)
      EMPMF_SQ_BANK_HI: sq_msg = {`EMPMF_ST_CC, chan_nib, 1'b0, `EMPMF_CC_BANK_HI, 1'b0, bank_hi_q};
      EMPMF_SQ_BANK_LO: sq_msg = {`EMPMF_ST_CC, chan_nib, 1'b0, `EMPMF_CC_BANK_LO, 1'b0, bank_lo_q};
      EMPMF_SQ_PROG: sq_msg = {`EMPMF_ST_PROG, chan_nib, 1'b0, prog_q, 8'h00};
      EMPMF_SQ_VOL: sq_msg = {`EMPMF_ST_CC, chan_nib, 1'b0, `EMPMF_CC_VOL, 1'b0, vol_q};
      default: sq_msg = 24'h000000;
    endcase
  end

  function automatic empmf_seq_t nxt(input empmf_seq_t s, input logic [7:0] en);
    empmf_seq_t r;
    r = EMPMF_SQ_IDLE;
    case (s)
      EMPMF_SQ_IDLE: r = en[`EMPMF_EN_BANK] ? EMPMF_SQ_BANK_HI :
        en[`EMPMF_EN_PROG] ? EMPMF_SQ_PROG : en[`EMPMF_EN_VOL] ? EMPMF_SQ_VOL : EMPMF_SQ_IDLE;
      EMPMF_SQ_BANK_HI: r = EMPMF_SQ_BANK_LO;
      EMPMF_SQ_BANK_LO: r = en[`EMPMF_EN_PROG] ? EMPMF_SQ_PROG :
        en[`EMPMF_EN_VOL] ? EMPMF_SQ_VOL : EMPMF_SQ_IDLE;
      EMPMF_SQ_PROG: r = en[`EMPMF_EN_VOL] ? EMPMF_SQ_VOL : EMPMF_SQ_IDLE;
      default: r = EMPMF_SQ_IDLE;
    endcase
    return r;
  endfunction : nxt

  // fifo feed: sequence has priority, events stall meanwhile
  wire sq_active = (seq_q != EMPMF_SQ_IDLE);
  wire fifo_ready;
  wire ev_push = !sq_active && part_on && ev_valid_in && ev_send;
  wire push = part_on && (sq_active || ev_push);
  wire [23:0] push_msg = sq_active ? sq_msg : ev_msg;
  assign ev_ready_out = !sq_active && !setup_load_in && !sq_go_q &&
    (fifo_ready || !part_on || !ev_send);
  wire ev_take = ev_valid_in && ev_ready_out;
  wire ev_pass = ev_take && part_on && ev_send;

  always_comb begin
    seq_d = seq_q;
    if (sq_go_q) seq_d = part_on ? nxt(EMPMF_SQ_IDLE, en_q) : EMPMF_SQ_IDLE;
    else if (sq_active && (fifo_ready || !part_on)) seq_d = nxt(seq_q, en_q);
  end

  // record of keys whose note-on went out
  always_comb begin
    sent_d = sent_q;
    if (ev_pass && is_on) sent_d[note_out] = 1'b1;
    if (ev_pass && is_off) sent_d[note_out] = 1'b0;
    if (!part_on) sent_d = '0;
  end

  wire up_wr_ok = upper_wr_in && (limit_wr_data_in >= lower_q) &&
    (limit_wr_data_in >= `EMPMF_VEL_MIN);
  wire lo_wr_ok = lower_wr_in && (limit_wr_data_in <= upper_q) &&
    (limit_wr_data_in >= `EMPMF_VEL_MIN);
  // learn from struck velocity, simultaneous learn sets both
  wire strike = ev_take && is_on;
  wire up_learn = strike && page_up_held_in &&
    (page_down_held_in || ev_d2_in >= lower_q);
  wire lo_learn = strike && page_down_held_in &&
    (page_up_held_in || ev_d2_in <= upper_q);

  // settings restored on setup select, channel stored
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      chan_q <= `EMPMF_CH_OFF;
      upper_q <= `EMPMF_VEL_MAX;
      lower_q <= `EMPMF_VEL_MIN;
      use_played_q <= 1'b1;
      defv_q <= `EMPMF_VEL_DEF;
      en_q <= 8'h00;
      bank_hi_q <= 7'h00;
      bank_lo_q <= 7'h00;
      prog_q <= 7'h00;
      vol_q <= `EMPMF_VEL_MAX;
      xpose_q <= 7'sh00;
    end else if (setup_load_in) begin
      chan_q <= part_channel_setting_in;
      upper_q <= vel_upper_in;
      lower_q <= vel_lower_in;
      use_played_q <= use_played_vel_in;
      defv_q <= (default_vel_in == 7'h00) ? `EMPMF_VEL_MIN : default_vel_in;
      en_q <= transmit_type_selector_in;
      bank_hi_q <= bank_hi_in;
      bank_lo_q <= bank_lo_in;
      prog_q <= program_in;
      vol_q <= volume_in;
      xpose_q <= (transpose_in > `EMPMF_XPOSE_LIM) ? `EMPMF_XPOSE_LIM :
        (transpose_in < -`EMPMF_XPOSE_LIM) ? -`EMPMF_XPOSE_LIM : transpose_in;
    end else begin
      if (up_learn) upper_q <= ev_d2_in;
      else if (up_wr_ok) upper_q <= limit_wr_data_in;
      if (lo_learn) lower_q <= ev_d2_in;
      else if (lo_wr_ok) lower_q <= limit_wr_data_in;
    end
  end

  // sequence state and note record
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      seq_q <= EMPMF_SQ_IDLE;
      sq_go_q <= 1'b0;
      sent_q <= '0;
    end else begin
      seq_q <= seq_d;
      sq_go_q <= setup_load_in;
      sent_q <= setup_load_in ? '0 : sent_d;
    end
  end

  empmf_fifo #(
    .WIDTH(`EMPMF_MSG_W),
    .DEPTH(`EMPMF_FIFO_DEPTH),
    .AW(`EMPMF_FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_valid_in(push),
    .wr_ready_out(fifo_ready),
    .wr_data_in(push_msg),
    .rd_valid_out(msg_valid_out),
    .rd_ready_in(msg_ready_in),
    .rd_data_out(msg_data_out)
  );

  // readback
  assign part_enabled_out = part_on;
  assign vel_upper_out = upper_q;
  assign vel_lower_out = lower_q;
  assign seq_busy_out = sq_active || sq_go_q;
endmodule : empmf_part

// *** dv/empmf_sink.sv ***
module empmf_sink (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // pace: 0 prompt, 1 every other cycle, 2 stall
  input wire logic [1:0] mode_in,
  // handshake toward the part
  output logic msg_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ready pattern, never ready while in reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      msg_ready_out <= 1'b0;
    end else begin
      msg_ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && !msg_ready_out);
    end
  end
endmodule : empmf_sink

// *** dv/empmf_part_chk.sv ***
module empmf_part_chk
  import empmf_pkg::*;
(
  // clock and reset
  input logic clk_in,
  input logic sys_rst_in,
  // setup and panel
  input logic setup_load_in,
  input logic [4:0] part_channel_setting_in,
  input logic [7:0] transmit_type_selector_in,
  input logic [6:0] bank_hi_in,
  input logic [6:0] bank_lo_in,
  input logic [6:0] program_in,
  input logic [6:0] volume_in,
  input logic upper_wr_in,
  input logic [6:0] limit_wr_data_in,
  input logic page_up_held_in,
  input logic page_down_held_in,
  // played events
  input logic ev_valid_in,
  input logic ev_ready_out,
  input logic [2:0] ev_kind_in,
  input logic [6:0] ev_d2_in,
  // messages and readback
  input logic msg_valid_out,
  input logic msg_ready_in,
  input logic [23:0] msg_data_out,
  input logic part_enabled_out,
  input logic [6:0] vel_upper_out,
  input logic [6:0] vel_lower_out,
  input logic seq_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] c_q;
  logic [6:0] hi_q, lo_q, pg_q, vl_q;
  logic all_q, mod_q;
  logic [2:0] n_q;
  // decoded helpers
  wire [7:0] sel = transmit_type_selector_in;
  wire ch_ok = part_channel_setting_in inside {[5'h01:5'h10]};
  wire acc = msg_valid_out && msg_ready_in;
  wire [3:0] cn = c_q[3:0] - 4'h1;
  wire on = ev_valid_in && ev_ready_out && ev_kind_in == EMPMF_EV_NOTE_ON;
  wire lrn = on && part_enabled_out && ev_d2_in != 7'h00;
  // capture restored setup, count messages sent since then
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      all_q <= 1'b0;
      mod_q <= 1'b0;
      n_q <= 3'h7;
    end else if (setup_load_in) begin
      {c_q, hi_q, lo_q} <= {part_channel_setting_in, bank_hi_in, bank_lo_in};
      {pg_q, vl_q} <= {program_in, volume_in};
      all_q <= ch_ok && sel[0] && sel[1] && sel[5] && !msg_valid_out;
      mod_q <= ch_ok && sel[2];
      n_q <= 3'h0;
    end else if (acc && n_q != 3'h7) begin
      n_q <= n_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_step(int k);
    acc && all_q && n_q == k;
  endsequence
  property p_msg(int k, logic [23:0] e);
    s_step(k) |-> msg_data_out == e;
  endproperty
  AST_ENABLE: assert property (setup_load_in |=> part_enabled_out == $past(ch_ok))
    else $error("part enable wrong after setup load");
  AST_UPPER_REFUSE: assert property (upper_wr_in && limit_wr_data_in < vel_lower_out
    && !ev_valid_in && !setup_load_in |=> $stable(vel_upper_out))
    else $error("crossing upper limit write taken");
  AST_LEARN_UP: assert property (lrn && page_up_held_in && !page_down_held_in
    && ev_d2_in >= vel_lower_out |=> vel_upper_out == $past(ev_d2_in))
    else $error("upper limit not learned");
  AST_LEARN_BOTH: assert property (lrn && page_up_held_in && page_down_held_in
    |=> vel_upper_out == $past(ev_d2_in) && vel_lower_out == $past(ev_d2_in))
    else $error("limits not learned together");
  AST_MOD_GATE: assert property (ev_valid_in && ev_ready_out && ev_kind_in == EMPMF_EV_MOD
    && !mod_q && !msg_valid_out && !seq_busy_out |=> !msg_valid_out)
    else $error("gated mod message sent");
  AST_BANK_HI: assert property (p_msg(0, {4'hb, cn, 8'h00, 1'b0, hi_q}))
    else $error("bank upper message wrong");
  AST_BANK_LO: assert property (p_msg(1, {4'hb, cn, 8'h20, 1'b0, lo_q}))
    else $error("bank lower message wrong");
  AST_PROG: assert property (p_msg(2, {4'hc, cn, 1'b0, pg_q, 8'h00}))
    else $error("program message wrong");
  AST_VOL: assert property (p_msg(3, {4'hb, cn, 8'h07, 1'b0, vl_q}))
    else $error("volume message wrong");
endmodule : empmf_part_chk
bind empmf_part empmf_part_chk u_chk (.*);

// *** dv/tb_top.sv ***
module tb_top
  import empmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    empmf_ev_t k;
    logic [6:0] a;
    logic [6:0] b;
    logic [23:0] e;
  } empmf_row_t;
  logic clk_in = '0, sys_rst_in = '1, setup_load_in = '0, use_played_vel_in = '0;
  logic upper_wr_in = '0, lower_wr_in = '0, page_up_held_in = '0, page_down_held_in = '0;
  logic ev_valid_in = '0, msg_ready_in, ev_ready_out, msg_valid_out, part_enabled_out;
  logic seq_busy_out;
  logic [4:0] part_channel_setting_in = '0;
  logic [6:0] vel_upper_in = 7'h64, vel_lower_in = 7'h14, default_vel_in = 7'h40;
  logic [6:0] bank_hi_in = 7'h05, bank_lo_in = 7'h06, program_in = 7'h09, volume_in = 7'h64;
  logic [6:0] limit_wr_data_in = '0, ev_d1_in = '0, ev_d2_in = '0, mod_cc_in = 7'h0b;
  logic [6:0] vel_upper_out, vel_lower_out;
  logic signed [6:0] transpose_in = 7'sh02;
  logic [7:0] transmit_type_selector_in = '0;
  logic [2:0] ev_kind_in = '0;
  logic [1:0] mode = '0;
  logic [23:0] msg_data_out;
  logic [23:0] ex[$], got[$];
  empmf_row_t rw[11];
  int fail_count = 0, num_checks = 0, cycles = 0;
  empmf_part u_dut (.*);
  empmf_sink u_sink (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .mode_in(mode),
    .msg_ready_out(msg_ready_in));
  // clock and hang guard
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // collect every message the far side takes
  always @(posedge clk_in) begin
    if (!sys_rst_in && msg_valid_out === 1'b1 && msg_ready_in === 1'b1) begin
      got.push_back(msg_data_out);
    end
  end
  function automatic logic [23:0] m(logic [3:0] s, logic [4:0] c, logic [6:0] a, b);
    return {s, c[3:0] - 4'h1, 1'b0, a, 1'b0, b};
  endfunction : m
  task automatic summarize;
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic cmp(input string nm, input logic [23:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic chkq(input string nm);
    cmp({nm, " count"}, 24'(ex.size()), 24'(got.size()));
    foreach (ex[i]) if (i < got.size()) cmp(nm, ex[i], got[i]);
    ex.delete();
    got.delete();
  endtask : chkq
  // wait until the fifo and the setup sequence are idle
  task automatic drain;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_in);
      if (i > 3 && msg_valid_out === 1'b0 && seq_busy_out === 1'b0) break;
    end
  endtask : drain
  // offer one event, held until taken or given up
  task automatic ev(input logic [2:0] k, input logic [6:0] a, b, output logic ok);
    {ev_kind_in, ev_d1_in, ev_d2_in, ev_valid_in} <= {k, a, b, 1'b1};
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk_in);
      ok = (ev_ready_out === 1'b1);
    end
    ev_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask : ev
  task automatic su(input logic [4:0] c, input logic [7:0] s, input logic u);
    {part_channel_setting_in, transmit_type_selector_in} <= {c, s};
    {use_played_vel_in, setup_load_in} <= {u, 1'b1};
    @(posedge clk_in);
    setup_load_in <= 1'b0;
    drain();
  endtask : su
  task automatic pw(input logic up, input logic [6:0] d);
    {upper_wr_in, lower_wr_in, limit_wr_data_in} <= {up, !up, d};
    @(posedge clk_in);
    {upper_wr_in, lower_wr_in} <= 2'h0;
    @(posedge clk_in);
  endtask : pw
  initial begin
    logic ok;
    int n;
    rw = '{'{EMPMF_EV_NOTE_ON, 7'h3c, 7'h32, m(4'h9, 5'h03, 7'h3e, 7'h32)},
      '{EMPMF_EV_NOTE_ON, 7'h46, 7'h65, 24'h0}, '{EMPMF_EV_NOTE_ON, 7'h47, 7'h13, 24'h0},
      '{EMPMF_EV_NOTE_ON, 7'h48, 7'h64, m(4'h9, 5'h03, 7'h4a, 7'h64)},
      '{EMPMF_EV_NOTE_ON, 7'h49, 7'h14, m(4'h9, 5'h03, 7'h4b, 7'h14)},
      '{EMPMF_EV_NOTE_OFF, 7'h3c, 7'h00, m(4'h8, 5'h03, 7'h3e, 7'h40)},
      '{EMPMF_EV_NOTE_OFF, 7'h46, 7'h00, 24'h0},
      '{EMPMF_EV_MOD, 7'h00, 7'h05, m(4'hb, 5'h03, 7'h0b, 7'h05)},
      '{EMPMF_EV_BEND, 7'h03, 7'h09, m(4'he, 5'h03, 7'h03, 7'h09)},
      '{EMPMF_EV_AFT, 7'h07, 7'h07, m(4'hd, 5'h03, 7'h07, 7'h00)},
      '{EMPMF_EV_SUS, 7'h00, 7'h7f, m(4'hb, 5'h03, 7'h40, 7'h7f)}};
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    cmp("upper", 24'h7f, 24'(vel_upper_out));
    cmp("lower", 24'h01, 24'(vel_lower_out));
    cmp("enabled", 24'h0, 24'(part_enabled_out));
    mode <= 2'h1;
    su(5'h03, 8'hff, 1'b1);
    ex = '{m(4'hb, 5'h03, 7'h00, 7'h05), m(4'hb, 5'h03, 7'h20, 7'h06),
      m(4'hc, 5'h03, 7'h09, 7'h00), m(4'hb, 5'h03, 7'h07, 7'h64)};
    chkq("setup");
    cmp("enabled", 24'h1, 24'(part_enabled_out));
    // table of played events
    for (int i = 0; i < 11; i++) begin
      ev(rw[i].k, rw[i].a, rw[i].b, ok);
      if (rw[i].e !== 24'h0) ex.push_back(rw[i].e);
    end
    drain();
    chkq("rows");
    su(5'h10, 8'h80, 1'b0);
    ev(EMPMF_EV_MOD, 7'h00, 7'h05, ok);
    ev(EMPMF_EV_NOTE_ON, 7'h3c, 7'h32, ok);
    ex = '{m(4'h9, 5'h10, 7'h3e, 7'h40)};
    drain();
    chkq("substitute");
    pw(1'b0, 7'h65);
    cmp("lower refused", 24'h14, 24'(vel_lower_out));
    pw(1'b1, 7'h13);
    cmp("upper refused", 24'h64, 24'(vel_upper_out));
    pw(1'b1, 7'h50);
    cmp("upper written", 24'h50, 24'(vel_upper_out));
    page_up_held_in <= 1'b1;
    ev(EMPMF_EV_NOTE_ON, 7'h3d, 7'h5a, ok);
    cmp("learn upper", 24'h5a, 24'(vel_upper_out));
    page_down_held_in <= 1'b1;
    ev(EMPMF_EV_NOTE_ON, 7'h3e, 7'h28, ok);
    cmp("learn both", 24'h2828, {9'h0, vel_upper_out, 1'b0, vel_lower_out});
    {page_up_held_in, page_down_held_in} <= 2'h0;
    drain();
    got.delete();
    su(5'h00, 8'hff, 1'b1);
    cmp("enabled", 24'h0, 24'(part_enabled_out));
    ev(EMPMF_EV_MOD, 7'h00, 7'h05, ok);
    ev(EMPMF_EV_NOTE_ON, 7'h3c, 7'h32, ok);
    drain();
    chkq("off");
    // fill the fifo against a stalled far side, then drain it
    mode <= 2'h2;
    su(5'h05, 8'h80, 1'b1);
    n = 0;
    for (int i = 0; i < 20; i++) begin
      ev(EMPMF_EV_NOTE_ON, 7'(i), 7'h32, ok);
      if (!ok) break;
      n++;
      ex.push_back(m(4'h9, 5'h05, 7'(i + 2), 7'h32));
    end
    cmp("fill", 24'h1, {23'h0, !ok && n >= 16});
    mode <= 2'h1;
    drain();
    chkq("drain");
    summarize();
  end
endmodule : tb_top
